// ==== hdl/fast_irq_pkg.sv ====
package fast_irq_pkg;
	// Registers are addressed by index; the bus byte address is four times the index.
	localparam int ADDR_W = 18;
	localparam logic [15:0] IDX_EDGE_SEL   = 16'hF1C0;
	localparam logic [15:0] IDX_CTRL0      = 16'hFF88;
	localparam logic [15:0] IDX_CTRL1      = 16'hFF8A;
	localparam logic [15:0] IDX_CTRL2      = 16'hFF8C;
	localparam logic [15:0] IDX_TRAP_FLAGS = 16'hFFAC;
	localparam logic [15:0] IDX_IRQ_STATUS = 16'hFFF0;
	localparam logic [15:0] IDX_IRQ_MASK   = 16'hFFF2;
	localparam logic [ADDR_W-1:0] ADDR_EDGE_SEL   = {IDX_EDGE_SEL, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_CTRL0      = {IDX_CTRL0, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_CTRL1      = {IDX_CTRL1, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_CTRL2      = {IDX_CTRL2, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_TRAP_FLAGS = {IDX_TRAP_FLAGS, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK   = {IDX_IRQ_MASK, 2'h0};
	// Register select codes shared by the read and write decoders.
	localparam logic [2:0] SEL_NONE  = 3'h0;
	localparam logic [2:0] SEL_EDGE  = 3'h1;
	localparam logic [2:0] SEL_CTRL0 = 3'h2;
	localparam logic [2:0] SEL_TFR   = 3'h5;
	localparam logic [2:0] SEL_STAT  = 3'h6;
	localparam logic [2:0] SEL_MASK  = 3'h7;
	// Field layout and reset values.
	localparam int REQ_BIT = 7;
	localparam int EN_BIT  = 6;
	localparam int PRIORITY_LEVEL_FIELD_HI = 5;
	localparam int PRIORITY_LEVEL_FIELD_LO = 2;
	localparam int PSW_LVL_HI = 15;
	localparam int PSW_LVL_LO = 12;
	localparam logic [3:0] LVL_MAX = 4'hF;
	localparam logic [5:0] EDGE_SEL_RESET = 6'h00;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [15:0] TFR_RESET = 16'h0000;
	localparam logic [15:0] TFR_MASK = 16'hE08F;
	localparam logic [4:0] STAT_RESET = 5'h00;
	localparam logic [1:0] ES_OFF  = 2'h0;
	localparam logic [1:0] ES_RISE = 2'h1;
	localparam logic [1:0] ES_FALL = 2'h2;
	localparam logic [1:0] ES_ANY  = 2'h3;
	// Trap condition index order is also the trap priority, 0 highest; 3 and up form class B.
	localparam int TRAP_N = 8;
	localparam int CLASS_B_FIRST = 3;
	localparam int TFR_POS [TRAP_N] = '{15, 14, 13, 7, 3, 2, 1, 0};
	localparam logic [7:0] CSP_TRAP = 8'h00;
	// Timing in clock half-periods and the derived cycle counts.
	localparam int CLK_NS = 20;
	localparam int TCL_NS = CLK_NS / 2;
	localparam int SAMPLE_TCL = 2;
	localparam int ROUND_TCL = 8;
	localparam int SAMPLE_CYC = SAMPLE_TCL * TCL_NS / CLK_NS;
	localparam int ROUND_CYC = ROUND_TCL * TCL_NS / CLK_NS;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum {T_IDLE, T_PUSH_PSW, T_PUSH_CSP, T_PUSH_IP, T_JUMP} trap_state_t;
endpackage

// ==== hdl/fast_ext_irq_and_trap_unit.sv ====
`timescale 1ns/1ns
// Behaviour
// - Fast pins are sampled every clock, which is every two half-periods.
// - One shared register holds an edge field per pin; each pin is independent.
// - Edge field: 00 off, 01 rising, 10 falling, 11 either edge.
// - Request arbitration runs only once every eight half-periods (four clocks).
// - Control register per source: request, enable, priority level, group level.
// - Traps bypass arbitration, are unmaskable and beat any interrupt request.
// - Software trap number selects a vector at four times the number.
// - Software trap pushes status, segment (if enabled), pointer; jumps with segment zero.
// - A software trap leaves every interrupt request flag untouched.
// - A software trap keeps the status word priority level unchanged.
// - Eight hardware trap conditions; the three class A ones each branch to their own assigned vector.
// - Class B hardware traps cancel the instruction; class A let it complete.
// - Simultaneous hardware trap conditions: only the highest priority one is serviced.
// - Hardware trap pushes context and raises priority level to fifteen.
// - A hardware trap sets its flag in the trap flag register.
// - Class B traps share one priority and one common vector.
module fast_ext_irq_and_trap_unit
	import fast_irq_pkg::*;
#(
	parameter logic [23:0] VEC_NMI     = 24'h000008,
	parameter logic [23:0] VEC_STKOF   = 24'h000010,
	parameter logic [23:0] VEC_STKUF   = 24'h000018,
	parameter logic [23:0] VEC_CLASS_B = 24'h000028
)(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output wire logic              awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output wire logic              wready,
	output logic      [1:0]        bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output wire logic              arready,
	output logic      [31:0]       rdata,
	output logic      [1:0]        rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic [2:0]        fast_irq_input,
	input  wire logic [15:0]       status_word,
	input  wire logic [7:0]        code_segment_pointer,
	input  wire logic [15:0]       instruction_pointer,
	input  wire logic              seg_enable,
	output logic                   irq_req,
	output logic      [1:0]        irq_src,
	output logic      [3:0]        irq_level,
	input  wire logic              irq_ack,
	input  wire logic              sw_trap_req,
	input  wire logic [6:0]        sw_trap_num,
	input  wire logic [TRAP_N-1:0] hw_trap_cond,
	output wire logic              trap_busy,
	output logic                   instr_cancel,
	output wire logic              push_valid,
	output logic      [15:0]       push_data,
	input  wire logic              push_ready,
	output wire logic              jump_valid,
	output logic      [23:0]       jump_vector,
	output logic      [15:0]       new_status_word,
	output wire logic [7:0]        new_csp,
	output wire logic              irq_out
);

	function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
		if (a == ADDR_EDGE_SEL)
			return SEL_EDGE;
		else if (a == ADDR_CTRL0)
			return SEL_CTRL0;
		else if (a == ADDR_CTRL1)
			return 3'(SEL_CTRL0 + 3'h1);
		else if (a == ADDR_CTRL2)
			return 3'(SEL_CTRL0 + 3'h2);
		else if (a == ADDR_TRAP_FLAGS)
			return SEL_TFR;
		else if (a == ADDR_IRQ_STATUS)
			return SEL_STAT;
		else if (a == ADDR_IRQ_MASK)
			return SEL_MASK;
		else
			return SEL_NONE;
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] s);
		return {s[1] ? nw[15:8] : old[15:8], s[0] ? nw[7:0] : old[7:0]};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Register bus slave.

	logic              aw_hold_r;
	logic              w_hold_r;
	logic [ADDR_W-1:0] waddr_r;
	logic [15:0]       wdata_r;
	logic [1:0]        wstrb_r;
	logic [5:0]        edge_sel_r;
	logic [2:0][7:0]   ctrl_r;
	logic [15:0]       tfr_r;
	logic [4:0]        stat_r;
	logic [4:0]        mask_r;

	wire       wr_fire = aw_hold_r & w_hold_r & ~bvalid;
	wire [2:0] wr_sel  = reg_sel(waddr_r);
	wire [2:0] rd_sel  = reg_sel(araddr);
	wire       rd_fire = arvalid & arready;
	wire [15:0] rd_word = (rd_sel == SEL_EDGE) ? {10'h000, edge_sel_r} :
		(rd_sel == SEL_CTRL0) ? {8'h00, ctrl_r[0]} :
		(rd_sel == 3'(SEL_CTRL0 + 3'h1)) ? {8'h00, ctrl_r[1]} :
		(rd_sel == 3'(SEL_CTRL0 + 3'h2)) ? {8'h00, ctrl_r[2]} :
		(rd_sel == SEL_TFR) ? tfr_r :
		(rd_sel == SEL_STAT) ? {11'h000, stat_r} :
		(rd_sel == SEL_MASK) ? {11'h000, mask_r} : 16'h0000;

	assign awready = ~aw_hold_r & ~bvalid;
	assign wready  = ~w_hold_r & ~bvalid;
	assign arready = ~rvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			waddr_r   <= '0;
			wdata_r   <= 16'h0000;
			wstrb_r   <= 2'h0;
			bvalid    <= 1'b0;
			bresp     <= RESP_OKAY;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_hold_r <= 1'b1;
				waddr_r   <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_hold_r <= 1'b1;
				wdata_r  <= wdata[15:0];
				wstrb_r  <= wstrb[1:0];
			end
			if (wr_fire)
			begin
				aw_hold_r <= 1'b0;
				w_hold_r  <= 1'b0;
				bvalid    <= 1'b1;
				bresp     <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
			end
			else if (bvalid && bready)
				bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid <= 1'b0;
			rdata  <= 32'h00000000;
			rresp  <= RESP_OKAY;
		end
		else if (rd_fire)
		begin
			rvalid <= 1'b1;
			rdata  <= {16'h0000, rd_word};
			rresp  <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end
		else if (rvalid && rready)
			rvalid <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Fast pin edge detection and request flags.

	logic [2:0]      pin_prev_r;
	logic            irq_req_r;
	wire  [2:0]      hit;
	wire  [2:0]      ctrl_wr;
	wire  [2:0]      cand;
	wire  [2:0][7:0] ctrl_nxt;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pin_prev_r <= 3'h0;
		else
			pin_prev_r <= fast_irq_input;
	end

	for (genvar i = 0; i < 3; i++)
	begin : g_pin
		localparam logic [2:0] MY_SEL = 3'(SEL_CTRL0 + i);
		wire [1:0] es   = edge_sel_r[2*i+1:2*i];
		wire       rise = fast_irq_input[i] & ~pin_prev_r[i];
		wire       fall = ~fast_irq_input[i] & pin_prev_r[i];
		wire       ack_clr = irq_ack & irq_req_r & (irq_src == 2'(i));
		wire [7:0] base = ctrl_wr[i] ? wdata_r[7:0] : ctrl_r[i];
		assign hit[i] = ((es == ES_RISE) & rise) | ((es == ES_FALL) & fall) | ((es == ES_ANY) & (rise | fall));
		assign ctrl_wr[i] = wr_fire & (wr_sel == MY_SEL) & wstrb_r[0];
		assign ctrl_nxt[i] = {(base[REQ_BIT] & ~ack_clr) | hit[i], base[6:0]};
		assign cand[i] = ctrl_r[i][REQ_BIT] & ctrl_r[i][EN_BIT] &
			(ctrl_r[i][PRIORITY_LEVEL_FIELD_HI:PRIORITY_LEVEL_FIELD_LO] > status_word[PSW_LVL_HI:PSW_LVL_LO]);
	end

	wire edge_wr = wr_fire & (wr_sel == SEL_EDGE) & wstrb_r[0];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			edge_sel_r <= EDGE_SEL_RESET;
			ctrl_r     <= {3{CTRL_RESET}};
		end
		else
		begin
			edge_sel_r <= edge_wr ? wdata_r[5:0] : edge_sel_r;
			ctrl_r     <= ctrl_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Arbitration rounds.

	logic [1:0] round_cnt_r;
	logic       win_found;
	logic [1:0] win_idx;
	logic [5:0] win_key;
	wire        round_tick = (round_cnt_r == 2'(ROUND_CYC - 1));
	wire        hw_any = |hw_trap_cond;
	wire        trap_hold = trap_busy | hw_any | sw_trap_req;

	always_comb
	begin
		win_found = 1'b0;
		win_idx   = 2'h0;
		win_key   = 6'h00;
		for (int k = 0; k < 3; k++)
		begin
			if (cand[k] && (!win_found || ctrl_r[k][5:0] > win_key))
			begin
				win_found = 1'b1;
				win_idx   = 2'(k);
				win_key   = ctrl_r[k][5:0];
			end
		end
	end

	assign irq_req = irq_req_r;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			round_cnt_r <= 2'h0;
			irq_req_r   <= 1'b0;
			irq_src     <= 2'h0;
			irq_level   <= 4'h0;
		end
		else
		begin
			round_cnt_r <= round_tick ? 2'h0 : round_cnt_r + 2'h1;
			if (irq_ack)
				irq_req_r <= 1'b0;
			else if (round_tick)
			begin
				irq_req_r <= win_found & ~trap_hold;
				irq_src   <= win_idx;
				irq_level <= win_key[5:2];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Trap entry.

	trap_state_t state_r;
	trap_state_t state_nxt;
	logic [2:0]  hw_idx;
	logic [7:0]  csp_r;
	logic [15:0] ip_r;
	logic        seg_r;
	wire         accept = (state_r == T_IDLE) & (hw_any | sw_trap_req);
	wire         is_class_b = (hw_idx >= 3'(CLASS_B_FIRST));

	always_comb
	begin
		hw_idx = 3'h0;
		for (int k = TRAP_N - 1; k >= 0; k--)
		begin
			if (hw_trap_cond[k])
				hw_idx = 3'(k);
		end
	end

	wire [23:0] hw_vec = (hw_idx == 3'h0) ? VEC_NMI : (hw_idx == 3'h1) ? VEC_STKOF :
		(hw_idx == 3'h2) ? VEC_STKUF : VEC_CLASS_B;
	wire [23:0] sw_vec = {15'h0000, sw_trap_num, 2'h0};
	wire [15:0] psw_entry = hw_any ? {LVL_MAX, status_word[PSW_LVL_LO-1:0]} : status_word;

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			T_IDLE:
				if (accept)
					state_nxt = T_PUSH_PSW;
			T_PUSH_PSW:
				if (push_ready)
					state_nxt = seg_r ? T_PUSH_CSP : T_PUSH_IP;
			T_PUSH_CSP:
				if (push_ready)
					state_nxt = T_PUSH_IP;
			T_PUSH_IP:
				if (push_ready)
					state_nxt = T_JUMP;
			default:
				state_nxt = T_IDLE;
		endcase
	end

	assign trap_busy  = (state_r != T_IDLE);
	assign push_valid = (state_r == T_PUSH_PSW) | (state_r == T_PUSH_CSP) | (state_r == T_PUSH_IP);
	assign jump_valid = (state_r == T_JUMP);
	assign new_csp    = CSP_TRAP;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			state_r <= T_IDLE;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			csp_r           <= 8'h00;
			ip_r            <= 16'h0000;
			seg_r           <= 1'b0;
			push_data       <= 16'h0000;
			jump_vector     <= 24'h000000;
			new_status_word <= 16'h0000;
			instr_cancel    <= 1'b0;
		end
		else
		begin
			instr_cancel <= accept & hw_any & is_class_b;
			if (accept)
			begin
				csp_r           <= code_segment_pointer;
				ip_r            <= instruction_pointer;
				seg_r           <= seg_enable;
				push_data       <= status_word;
				jump_vector     <= hw_any ? hw_vec : sw_vec;
				new_status_word <= psw_entry;
			end
			else if (push_ready && state_r == T_PUSH_PSW)
				push_data <= seg_r ? {8'h00, csp_r} : ip_r;
			else if (push_ready && state_r == T_PUSH_CSP)
				push_data <= ip_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Trap flags, event status and interrupt output.

	logic [15:0] tfr_set;
	wire  [4:0]  events = {accept & ~hw_any, accept & hw_any, hit};
	wire  [15:0] tfr_base = (wr_fire && wr_sel == SEL_TFR) ? merge16(tfr_r, wdata_r, wstrb_r) : tfr_r;
	wire  [4:0]  stat_clr = (wr_fire && wr_sel == SEL_STAT && wstrb_r[0]) ? wdata_r[4:0] : 5'h00;
	wire         mask_wr = wr_fire & (wr_sel == SEL_MASK) & wstrb_r[0];

	always_comb
	begin
		tfr_set = 16'h0000;
		for (int k = 0; k < TRAP_N; k++)
			tfr_set[TFR_POS[k]] = accept & hw_trap_cond[k];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tfr_r  <= TFR_RESET;
			stat_r <= STAT_RESET;
			mask_r <= STAT_RESET;
		end
		else
		begin
			tfr_r  <= (tfr_base | tfr_set) & TFR_MASK;
			stat_r <= (stat_r & ~stat_clr) | events;
			mask_r <= mask_wr ? wdata_r[4:0] : mask_r;
		end
	end

	assign irq_out = |(stat_r & mask_r);

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	edge_rise_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(edge_sel_r[1:0] == ES_RISE && fast_irq_input[0] && !pin_prev_r[0]) |=> ctrl_r[0][REQ_BIT])
		else $error("rising edge did not set request flag");
	edge_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(edge_sel_r[3:2] == ES_OFF && !ctrl_r[1][REQ_BIT] && !ctrl_wr[1]) |=> !ctrl_r[1][REQ_BIT])
		else $error("disabled pin raised a request");
	arb_round_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(irq_req_r) |-> $past(round_tick) && $past(round_cnt_r) == 2'h3)
		else $error("request granted outside a round");
	trap_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(irq_req_r) |-> !$past(trap_hold))
		else $error("interrupt granted while a trap was due");
	sw_vector_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(accept && !hw_any) |=> jump_vector == {15'h0000, $past(sw_trap_num), 2'h0})
		else $error("software trap vector wrong");
	push_order_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_r == T_PUSH_PSW && push_ready && !seg_r) |=> state_r == T_PUSH_IP && push_data == ip_r)
		else $error("context push order wrong");
	sw_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(accept && !hw_any) |=> new_status_word == $past(status_word))
		else $error("software trap changed status word");
	hw_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(accept && hw_any) |=> new_status_word[PSW_LVL_HI:PSW_LVL_LO] == 4'hF)
		else $error("hardware trap level not fifteen");
	nmi_prio_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(accept && hw_trap_cond[0]) |=> jump_vector == VEC_NMI && tfr_r[15])
		else $error("top trap not serviced or not flagged");
	class_b_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(accept && hw_trap_cond[2:0] == 3'h0 && hw_any) |=> jump_vector == VEC_CLASS_B && instr_cancel)
		else $error("class B trap vector or cancel wrong");
	jump_seq_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_r == T_PUSH_IP && push_ready) |=> jump_valid ##1 !trap_busy)
		else $error("jump did not follow last push");

endmodule

// ==== test/pin_source.sv ====
`timescale 1ns/1ns
// Stands in for the signal sources on the three fast pins.
// In slow mode a level change reaches the pin two clocks late, like a source behind a long settling path.
module pin_source
(
	input  wire logic       aclk,
	input  wire logic [2:0] level,
	input  wire logic       slow,
	output logic      [2:0] pins
);
	logic [2:0] d1_r = 3'h0;
	logic [2:0] d2_r = 3'h0;

	initial pins = 3'h0;

	always @(posedge aclk)
	begin
		d1_r <= level;
		d2_r <= d1_r;
		pins <= slow ? d2_r : level;
	end
endmodule

// ==== test/fast_ext_irq_and_trap_unit_test.sv ====
`timescale 1ns/1ns
module fast_ext_irq_and_trap_unit_test;
	import fast_irq_pkg::*;
	localparam logic [23:0] VEC_A0 = 24'h000008;
	localparam logic [23:0] VEC_A1 = 24'h000010;
	localparam logic [23:0] VEC_A2 = 24'h000018;
	localparam logic [23:0] VEC_B  = 24'h000028;
	logic              aclk = 1'b0;
	logic              aresetn = 1'b0;
	logic [ADDR_W-1:0] awaddr = '0;
	logic [ADDR_W-1:0] araddr = '0;
	logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0]       wdata = 32'h00000000;
	logic [3:0]        wstrb = 4'h0;
	logic [15:0]       status_word = 16'h0000, instruction_pointer = 16'h0000;
	logic [7:0]        code_segment_pointer = 8'h00, hw_trap_cond = 8'h00;
	logic              seg_enable = 1'b0, irq_ack = 1'b0, sw_trap_req = 1'b0, push_ready = 1'b0;
	logic [6:0]        sw_trap_num = 7'h00;
	logic [2:0]        pin_level = 3'h0, pins;
	logic              pin_slow = 1'b0;
	logic              awready, wready, bvalid, arready, rvalid, irq_req, trap_busy, instr_cancel;
	logic              push_valid, jump_valid, irq_out;
	logic [1:0]        bresp, rresp, irq_src;
	logic [31:0]       rdata;
	logic [3:0]        irq_level;
	logic [15:0]       push_data, new_status_word;
	logic [23:0]       jump_vector;
	logic [7:0]        new_csp;
	logic [31:0]       seed = 32'h0000005E;
	logic [47:0]       rd_q[$], push_q[$], jump_q[$];
	int                err_total = 0, checks_done = 0, cyc = 0;

	pin_source i_pins (.aclk(aclk), .level(pin_level), .slow(pin_slow), .pins(pins));

	fast_ext_irq_and_trap_unit #(.VEC_NMI(VEC_A0), .VEC_STKOF(VEC_A1), .VEC_STKUF(VEC_A2), .VEC_CLASS_B(VEC_B)) i_dut
	(
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .fast_irq_input(pins), .status_word(status_word),
		.code_segment_pointer(code_segment_pointer), .instruction_pointer(instruction_pointer),
		.seg_enable(seg_enable), .irq_req(irq_req), .irq_src(irq_src), .irq_level(irq_level),
		.irq_ack(irq_ack), .sw_trap_req(sw_trap_req), .sw_trap_num(sw_trap_num), .hw_trap_cond(hw_trap_cond),
		.trap_busy(trap_busy), .instr_cancel(instr_cancel), .push_valid(push_valid), .push_data(push_data),
		.push_ready(push_ready), .jump_valid(jump_valid), .jump_vector(jump_vector),
		.new_status_word(new_status_word), .new_csp(new_csp), .irq_out(irq_out)
	);

	always #10 aclk = ~aclk;

	// The stack stalls one cycle in three so some pushes have to wait for it.
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		push_ready <= (cyc % 3) != 0;
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
		checks_done++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic timeout(input string what);
		err_total++;
		$display("Error %s expected 1 seen 0", what);
		end_of_test();
	endtask

	task automatic take(ref logic [47:0] q[$], input string what, input logic [47:0] got);
		if (q.size() == 0)
			chk(what, 48'hFFFFFFFFFFFF, got);
		else
			chk(what, q.pop_front(), got);
	endtask

	// Every read, push and jump result that shows at the outputs is matched against the oldest note of its kind.
	always @(posedge aclk)
	begin
		if (aresetn === 1'b1 && rvalid === 1'b1 && rready === 1'b1)
			take(rd_q, "read", {14'h0, rresp, rdata});
		if (aresetn === 1'b1 && push_valid === 1'b1 && push_ready === 1'b1)
			take(push_q, "push_data", {32'h0, push_data});
		if (aresetn === 1'b1 && jump_valid === 1'b1)
			take(jump_q, "jump", {jump_vector, new_status_word, new_csp});
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d, input logic [1:0] resp);
		int n;
		awaddr <= a;
		wdata <= {16'h0000, d};
		wstrb <= 4'h3;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
			if (awvalid && awready === 1'b1) awvalid <= 1'b0;
			if (wvalid && wready === 1'b1) wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1 && n < 40);
		bready <= 1'b0;
		// Let one edge pass so a following write never raises bready in the step that lowered it.
		@(posedge aclk);
		if (n >= 40) timeout("bvalid");
		chk("bresp", resp, bresp);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] resp);
		int n;
		rd_q.push_back({14'h0, resp, d});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
			if (arvalid && arready === 1'b1) arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1 && n < 40);
		rready <= 1'b0;
		@(posedge aclk);
		if (n >= 40) timeout("rvalid");
	endtask

	task automatic wait_irq(input logic [1:0] src, input logic [3:0] lvl);
		int n;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (irq_req !== 1'b1 && n < 12);
		if (n >= 12) timeout("irq_req");
		chk("irq_src", src, irq_src);
		chk("irq_level", lvl, irq_level);
		irq_ack <= 1'b1;
		@(posedge aclk);
		irq_ack <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic wait_busy(input logic lvl);
		int n;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (trap_busy !== lvl && n < 40);
		if (n >= 40) timeout("trap_busy");
	endtask

	task automatic trap(input logic hw, input logic [7:0] cond, input logic [6:0] num, input logic seg);
		logic [31:0] r;
		logic [23:0] vec;
		int          idx;
		r = xs();
		idx = 0;
		while (hw && idx < 7 && !cond[idx]) idx++;
		vec = !hw ? {15'h0, num, 2'b00} : idx == 0 ? VEC_A0 : idx == 1 ? VEC_A1 : idx == 2 ? VEC_A2 : VEC_B;
		push_q.push_back(r[15:0]);
		if (seg) push_q.push_back({8'h00, r[23:16]});
		push_q.push_back(r[31:16]);
		jump_q.push_back({vec, hw ? {LVL_MAX, r[11:0]} : r[15:0], 8'h00});
		status_word <= r[15:0];
		code_segment_pointer <= r[23:16];
		instruction_pointer <= r[31:16];
		seg_enable <= seg;
		hw_trap_cond <= hw ? cond : 8'h00;
		sw_trap_req <= !hw;
		sw_trap_num <= num;
		wait_busy(1'b1);
		chk("instr_cancel", hw && idx >= CLASS_B_FIRST, instr_cancel);
		hw_trap_cond <= 8'h00;
		sw_trap_req <= 1'b0;
		wait_busy(1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#1000000;
		timeout("watchdog");
	end

	initial
	begin
		logic [ADDR_W-1:0] regs [7];
		logic [1:0]        m;
		logic [15:0]       tfr_exp;
		logic [31:0]       r;
		regs = '{ADDR_EDGE_SEL, ADDR_CTRL0, ADDR_CTRL1, ADDR_CTRL2, ADDR_TRAP_FLAGS, ADDR_IRQ_STATUS, ADDR_IRQ_MASK};
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		foreach (regs[i]) rd(regs[i], 32'h0, RESP_OKAY);
		rd(18'h00004, 32'h0, RESP_SLVERR);
		wr(18'h00004, 16'h1234, RESP_SLVERR);
		wr(ADDR_CTRL0, 16'hFF3F, RESP_OKAY);
		rd(ADDR_CTRL0, 32'h3F, RESP_OKAY);
		wr(ADDR_CTRL0, 16'h0000, RESP_OKAY);
		$display("test registers done");
		for (int k = 0; k < 4; k++)
		begin
			m = k[1:0];
			pin_slow <= m[0];
			wr(ADDR_EDGE_SEL, {12'h000, ~m, m}, RESP_OKAY);
			pin_level <= 3'h3;
			repeat (6) @(posedge aclk);
			rd(ADDR_CTRL0, {24'h0, m[0], 7'h0}, RESP_OKAY);
			rd(ADDR_CTRL1, {24'h0, ~m[0], 7'h0}, RESP_OKAY);
			wr(ADDR_CTRL0, 16'h0000, RESP_OKAY);
			wr(ADDR_CTRL1, 16'h0000, RESP_OKAY);
			pin_level <= 3'h0;
			repeat (6) @(posedge aclk);
			rd(ADDR_CTRL0, {24'h0, m[1], 7'h0}, RESP_OKAY);
			rd(ADDR_CTRL1, {24'h0, ~m[1], 7'h0}, RESP_OKAY);
			wr(ADDR_CTRL0, 16'h0000, RESP_OKAY);
			wr(ADDR_CTRL1, 16'h0000, RESP_OKAY);
		end
		$display("test edge select done");
		rd(ADDR_IRQ_STATUS, 32'h3, RESP_OKAY);
		chk("irq_out", 1'b0, irq_out);
		wr(ADDR_IRQ_MASK, 16'h0001, RESP_OKAY);
		@(posedge aclk);
		chk("irq_out", 1'b1, irq_out);
		wr(ADDR_IRQ_STATUS, 16'h0001, RESP_OKAY);
		@(posedge aclk);
		chk("irq_out", 1'b0, irq_out);
		rd(ADDR_IRQ_STATUS, 32'h2, RESP_OKAY);
		wr(ADDR_IRQ_STATUS, 16'h001F, RESP_OKAY);
		wr(ADDR_IRQ_MASK, 16'h0000, RESP_OKAY);
		$display("test status mask done");
		wr(ADDR_EDGE_SEL, 16'h0015, RESP_OKAY);
		wr(ADDR_CTRL0, 16'h0048, RESP_OKAY);
		wr(ADDR_CTRL1, 16'h004C, RESP_OKAY);
		wr(ADDR_CTRL2, 16'h0049, RESP_OKAY);
		status_word <= 16'h2000;
		pin_level <= 3'h7;
		wait_irq(2'h1, 4'h3);
		status_word <= 16'h0000;
		wait_irq(2'h2, 4'h2);
		wait_irq(2'h0, 4'h2);
		repeat (12) @(posedge aclk);
		chk("irq_req", 1'b0, irq_req);
		rd(ADDR_CTRL1, 32'h4C, RESP_OKAY);
		rd(ADDR_CTRL2, 32'h49, RESP_OKAY);
		wr(ADDR_CTRL0, 16'h0080, RESP_OKAY);
		wr(ADDR_CTRL1, 16'h0000, RESP_OKAY);
		wr(ADDR_CTRL2, 16'h0000, RESP_OKAY);
		wr(ADDR_IRQ_STATUS, 16'h001F, RESP_OKAY);
		$display("test arbitration done");
		r = xs();
		trap(1'b0, 8'h00, r[6:0], 1'b1);
		trap(1'b0, 8'h00, 7'h7F, 1'b0);
		rd(ADDR_CTRL0, 32'h80, RESP_OKAY);
		wr(ADDR_CTRL0, 16'h0000, RESP_OKAY);
		$display("test software trap done");
		tfr_exp = 16'h0000;
		for (int i = 0; i < TRAP_N; i++)
		begin
			trap(1'b1, 8'h01 << i, 7'h00, i[0]);
			tfr_exp[TFR_POS[i]] = 1'b1;
		end
		rd(ADDR_TRAP_FLAGS, {16'h0, tfr_exp}, RESP_OKAY);
		wr(ADDR_TRAP_FLAGS, 16'h0000, RESP_OKAY);
		trap(1'b1, 8'hA6, 7'h00, 1'b1);
		rd(ADDR_TRAP_FLAGS, 32'h6005, RESP_OKAY);
		rd(ADDR_IRQ_STATUS, 32'h18, RESP_OKAY);
		$display("test hardware trap done");
		repeat (10) @(posedge aclk);
		chk("pending", 48'h0, rd_q.size() + push_q.size() + jump_q.size());
		end_of_test();
	end
endmodule
